// *** src/ffd_consts.svh ***
`ifndef FFD_CONSTS_SVH
`define FFD_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define FFD_OFF_DIAG      12'h000
`define FFD_OFF_STATUS    12'h004
`define FFD_OFF_MASK      12'h008
`define FFD_OFF_CTRL      12'h00c
`define FFD_OFF_OC_A      12'h010
`define FFD_OFF_OC_B      12'h014
`define FFD_OFF_OC_C      12'h018
`define FFD_OFF_FAULTS    12'h01c
`define FFD_OFF_SMERR     12'h020
`define FFD_OFF_OCLIM     12'h024
`define FFD_OFF_OCWARN    12'h028
`define FFD_OFF_PTLIM     12'h02c
// ****************************************
// Diagnostic word bit positions
// ****************************************
`define FFD_B_SMWD        0
`define FFD_B_SYNCWD      1
`define FFD_B_PLL         2
`define FFD_B_SYNCWIN     3
`define FFD_B_HWFAIL      8
`define FFD_B_EEOLD       9
`define FFD_B_EESCHED     10
`define FFD_B_EEFAIL      11
`define FFD_DIAG_MASK     32'h00000f0f
// ****************************************
// Status/event bit positions
// ****************************************
`define FFD_E_COMMFLT     0
`define FFD_E_COMMWARN    1
`define FFD_E_OCWARN      2
`define FFD_E_OCFLT       3
`define FFD_E_PTWARN      4
`define FFD_E_PTFLT       5
`define FFD_E_CMDFAIL     6
`define FFD_NEVT          7
// ****************************************
// Control bits and reset values
// ****************************************
`define FFD_C_PTMASK      0
`define FFD_C_EEAUTO      1
`define FFD_OCLIM_RST     32'h00000400
`define FFD_OCWARN_RST    32'h00000100
`define FFD_PTLIM_RST     32'h00001000
// Sync window tolerance cap, 1 ms in ns, and cycle period in ns
`define FFD_WIN_CAP_NS    1000000
`define FFD_CLK_NS        4
`define FFD_WIN_CAP_CYC   (`FFD_WIN_CAP_NS / `FFD_CLK_NS)
`endif

// *** src/ffd_pkg.sv ***
package ffd_pkg;
  // Sync window checker states
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT = 2'b01,
    SW_OPEN = 2'b10
  } ffd_sw_e;
  // Overcurrent escalation states
  typedef enum logic [1:0] {
    OC_IDLE = 2'b00,
    OC_WARN = 2'b01,
    OC_FLT  = 2'b10
  } ffd_oc_e;
  // Three phase currents
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } ffd_phase_s;
  // Fieldbus link indications
  typedef struct packed {
    logic smWdExpired;
    logic syncWdExpired;
    logic pllUnlocked;
    logic rxPdo;
    logic sync0;
    logic hwFail;
  } ffd_link_s;
endpackage

// *** src/ffd_sync_window.sv ***
`include "ffd_consts.svh"
// Checks each received process data frame lands within
// [T/2, T + min(T/2, cap)] after sync signal zero.
module ffd_sync_window #(
  parameter int CW = 24
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          sync0,
  input  wire logic          rxPdo,
  output logic               winErr
);
  initial begin
    if (CW < 19) $error("ffd_sync_window: CW too small for 1 ms cap");
  end
  ffd_pkg::ffd_sw_e  state_q;
  logic [CW-1:0]     cnt_q;
  logic [CW-1:0]     age_q;
  logic [CW-1:0]     period_q;
  logic [CW-1:0]     half;
  logic [CW-1:0]     late;
  assign half = period_q >> 1;
  assign late = period_q + ((half > CW'(`FFD_WIN_CAP_CYC)) ?
                CW'(`FFD_WIN_CAP_CYC) : half);
  // Period measured between sync pulses, saturating
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q    <= '0;
      period_q <= '0;
    end else if (sync0) begin
      cnt_q    <= '0;
      period_q <= cnt_q;
    end else if (cnt_q != '1) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  // Time since the sync that opened the window. Later syncs do not
  // restart it, so late or missing data is still caught
  always_ff @(posedge core_clk) begin
    if (rst) begin
      age_q <= '0;
    end else if (state_q == ffd_pkg::SW_WAIT && sync0) begin
      age_q <= '0;
    end else if (age_q != '1) begin
      age_q <= age_q + 1'b1;
    end
  end
  // Window check; first sync only learns the period
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ffd_pkg::SW_IDLE;
      winErr  <= 1'b0;
    end else begin
      winErr <= 1'b0;
      case (state_q)
        ffd_pkg::SW_IDLE: if (sync0) state_q <= ffd_pkg::SW_WAIT;
        ffd_pkg::SW_WAIT: if (sync0) state_q <= ffd_pkg::SW_OPEN;
        ffd_pkg::SW_OPEN: begin
          if (rxPdo && (age_q < half || age_q > late)) begin
            winErr <= 1'b1;
          end
          if (rxPdo) state_q <= ffd_pkg::SW_WAIT;
          else if (age_q > late) begin
            winErr  <= 1'b1;
            state_q <= ffd_pkg::SW_WAIT;
          end
        end
        default: state_q <= ffd_pkg::SW_IDLE;
      endcase
    end
  end
endmodule

// *** src/ffd_overcurrent.sv ***
`include "ffd_consts.svh"
// Per-phase overcurrent capture with warning to fault escalation
module ffd_overcurrent #(
  parameter int W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              faultReset,
  input  wire ffd_pkg::ffd_phase_s phase,
  input  wire logic [15:0]       limit,
  input  wire logic [31:0]       warnCycles,
  output logic [15:0]            peakA,
  output logic [15:0]            peakB,
  output logic [15:0]            peakC,
  output logic                   ocWarn,
  output logic                   ocFault
);
  initial begin
    if (W != 16) $error("ffd_overcurrent: W must be 16");
  end
  ffd_pkg::ffd_oc_e state_q;
  logic [31:0]      dur_q;
  logic [2:0]       over;
  assign over = {phase.a > limit, phase.b > limit, phase.c > limit};
  // Peak magnitude per phase, kept until fault reset
  always_ff @(posedge core_clk) begin
    if (rst || faultReset) begin
      peakA <= '0;
      peakB <= '0;
      peakC <= '0;
    end else begin
      if (over[2] && phase.a > peakA) peakA <= phase.a;
      if (over[1] && phase.b > peakB) peakB <= phase.b;
      if (over[0] && phase.c > peakC) peakC <= phase.c;
    end
  end
  // Short overcurrent warns; one lasting past warnCycles faults
  always_ff @(posedge core_clk) begin
    if (rst || faultReset) begin
      state_q <= ffd_pkg::OC_IDLE;
      dur_q   <= '0;
    end else begin
      case (state_q)
        ffd_pkg::OC_IDLE: if (|over) begin
          state_q <= ffd_pkg::OC_WARN;
          dur_q   <= 32'h00000001;
        end
        ffd_pkg::OC_WARN: begin
          if (!(|over)) state_q <= ffd_pkg::OC_IDLE;
          else if (dur_q >= warnCycles) state_q <= ffd_pkg::OC_FLT;
          else dur_q <= dur_q + 32'h00000001;
        end
        ffd_pkg::OC_FLT: state_q <= ffd_pkg::OC_FLT;
        default: state_q <= ffd_pkg::OC_IDLE;
      endcase
    end
  end
  assign ocWarn  = (state_q == ffd_pkg::OC_WARN);
  assign ocFault = (state_q == ffd_pkg::OC_FLT);
endmodule

// *** src/ffd_fault_diag.sv ***
`include "ffd_consts.svh"
module ffd_fault_diag #(
  parameter int CW = 24
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire ffd_pkg::ffd_link_s  link,
  input  wire ffd_pkg::ffd_phase_s phase,
  input  wire logic [31:0]         trackErr,
  input  wire logic                eeOutdated,
  input  wire logic                fwDownloadDone,
  input  wire logic                powerUp,
  input  wire logic                eeUpdateOk,
  input  wire logic                eeUpdateFail,
  input  wire logic                cmdDone,
  input  wire logic                cmdOk,
  input  wire logic [15:0]         cmdErrCode,
  input  wire logic                faultReset,
  output logic                     eeUpdateStart,
  output logic                     irq,
  output logic                     fault,
  output logic                     warning
);
  initial begin
    if (CW < 19) $error("ffd_fault_diag: CW too small");
    if (`FFD_NEVT > 32) $error("ffd_fault_diag: too many events");
  end
  // ****************************************
  // Registers and wires
  // ****************************************
  logic [31:0] diag_q;
  logic [`FFD_NEVT-1:0] status_q;
  logic [31:0] mask_q;
  logic [31:0] ctrl_q;
  logic [31:0] ocLim_q;
  logic [31:0] ocWarnCyc_q;
  logic [31:0] ptLim_q;
  logic [15:0] smErr_q;
  logic        cmdFail_q;
  logic        eePending_q;
  logic        winErr;
  logic [15:0] peakA;
  logic [15:0] peakB;
  logic [15:0] peakC;
  logic        ocWarn;
  logic        ocFault;
  logic        ptOver;
  logic        ptFault;
  logic [`FFD_NEVT-1:0] evt;
  logic        wrEn;
  logic        rdEn;
  logic [31:0] rdMux;
  logic        hit;
  logic [31:0] faultVec;
  logic [2:0]  warnVec;
  logic [31:0] diagSet;
  logic        stsClr;

  // Decode one register offset
  function automatic logic isReg(input logic [11:0] a,
                                 input logic [11:0] off);
    return a == off;
  endfunction

  // ****************************************
  // Sub-blocks
  // ****************************************
  ffd_sync_window #(.CW(CW)) uWin (
    .core_clk (core_clk),
    .rst      (rst),
    .sync0    (link.sync0),
    .rxPdo    (link.rxPdo),
    .winErr   (winErr)
  );
  ffd_overcurrent #(.W(16)) uOc (
    .core_clk   (core_clk),
    .rst        (rst),
    .faultReset (faultReset),
    .phase      (phase),
    .limit      (ocLim_q[15:0]),
    .warnCycles (ocWarnCyc_q),
    .peakA      (peakA),
    .peakB      (peakB),
    .peakC      (peakC),
    .ocWarn     (ocWarn),
    .ocFault    (ocFault)
  );

  // ****************************************
  // Diagnostic word
  // ****************************************
  // Set requests, one per defined bit; reserved bits never set
  always_comb begin
    diagSet                 = 32'h0;
    diagSet[`FFD_B_SMWD]    = link.smWdExpired;
    diagSet[`FFD_B_SYNCWD]  = link.syncWdExpired;
    diagSet[`FFD_B_PLL]     = link.pllUnlocked;
    diagSet[`FFD_B_SYNCWIN] = winErr;
    diagSet[`FFD_B_HWFAIL]  = link.hwFail;
    diagSet[`FFD_B_EEOLD]   = eeOutdated;
    diagSet[`FFD_B_EESCHED] = eePending_q;
    diagSet[`FFD_B_EEFAIL]  = eeUpdateFail;
  end
  // Sticky until fault reset; a set in the reset cycle wins, so an
  // event that coincides with the reset is never lost
  always_ff @(posedge core_clk) begin
    if (rst) begin
      diag_q <= '0;
    end else begin
      diag_q <= ((faultReset ? 32'h0 : diag_q) | diagSet)
                & `FFD_DIAG_MASK;
    end
  end

  // ****************************************
  // EEPROM automatic update scheduling
  // ****************************************
  // Armed by a finished download, cleared once the update reports
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eePending_q <= 1'b0;
    end else if (ctrl_q[`FFD_C_EEAUTO] && eeOutdated &&
                 fwDownloadDone) begin
      eePending_q <= 1'b1;
    end else if (eeUpdateOk || eeUpdateFail) begin
      eePending_q <= 1'b0;
    end
  end
  // Start pulse on a power-up seen while armed; the update itself
  // runs elsewhere, this block only schedules it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eeUpdateStart <= 1'b0;
    end else begin
      eeUpdateStart <= eePending_q && powerUp;
    end
  end

  // ****************************************
  // Tracking error and command failure
  // ****************************************
  // Over the limit: warning always, fault only while unmasked
  assign ptOver  = trackErr > ptLim_q;
  assign ptFault = ptOver && !ctrl_q[`FFD_C_PTMASK];
  // Failed command keeps its code until next command completes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmdFail_q <= 1'b0;
      smErr_q   <= '0;
    end else if (cmdDone) begin
      cmdFail_q <= !cmdOk;
      smErr_q   <= cmdOk ? 16'h0000 : cmdErrCode;
    end
  end

  // ****************************************
  // Events, status, interrupt
  // ****************************************
  // Event sources are levels, looked at again every cycle
  assign evt[`FFD_E_COMMFLT]  = |diag_q[3:0];
  assign evt[`FFD_E_COMMWARN] = |diag_q[11:8];
  assign evt[`FFD_E_OCWARN]   = ocWarn;
  assign evt[`FFD_E_OCFLT]    = ocFault;
  assign evt[`FFD_E_PTWARN]   = ptOver;
  assign evt[`FFD_E_PTFLT]    = ptFault;
  assign evt[`FFD_E_CMDFAIL]  = cmdFail_q;
  assign wrEn   = psel && penable && pwrite;
  assign rdEn   = psel && !penable && !pwrite;
  assign stsClr = wrEn && isReg(paddr, `FFD_OFF_STATUS);

  // ****************************************
  // Status register
  // ****************************************
  // One flop per event. Write one to clear, but a new event in the
  // same cycle wins: a level event still present sets its bit again
  // at once, so software cannot lose it by clearing early
  generate
    for (genvar g = 0; g < `FFD_NEVT; g++) begin : gStatus
      always_ff @(posedge core_clk) begin
        if (rst) begin
          status_q[g] <= 1'b0;
        end else if (evt[g]) begin
          status_q[g] <= 1'b1;
        end else if (stsClr && pwdata[g]) begin
          status_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // Interrupt, fault and warning outputs
  // ****************************************
  // Faults: comm timing bits, overcurrent fault, unmasked tracking
  assign faultVec = {29'h0, ptFault, ocFault, |diag_q[3:0]};
  // Warnings: comm warning bits, overcurrent, tracking; the
  // tracking warning ignores the fault mask on purpose
  assign warnVec  = {ptOver, ocWarn, |diag_q[11:8]};
  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q[`FFD_NEVT-1:0]);
    end
  end
  // Fault flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault <= 1'b0;
    end else begin
      fault <= |faultVec;
    end
  end
  // Warning flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      warning <= 1'b0;
    end else begin
      warning <= |warnVec;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  // Writable configuration; unused bits are dropped at write so
  // that readback shows only what the logic acts on
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_q      <= '0;
      ctrl_q      <= '0;
      ocLim_q     <= `FFD_OCLIM_RST;
      ocWarnCyc_q <= `FFD_OCWARN_RST;
      ptLim_q     <= `FFD_PTLIM_RST;
    end else if (wrEn) begin
      if (isReg(paddr, `FFD_OFF_MASK))   mask_q <= pwdata & 32'h7f;
      if (isReg(paddr, `FFD_OFF_CTRL))   ctrl_q <= pwdata & 32'h3;
      if (isReg(paddr, `FFD_OFF_OCLIM))  ocLim_q <= pwdata & 32'hffff;
      if (isReg(paddr, `FFD_OFF_OCWARN)) ocWarnCyc_q <= pwdata;
      if (isReg(paddr, `FFD_OFF_PTLIM))  ptLim_q <= pwdata;
    end
  end
  // Read mux; diagnostic word is read-only. Unmapped offsets
  // answer with an error and read as zero
  always_comb begin
    hit   = 1'b1;
    rdMux = 32'h0;
    case (paddr)
      `FFD_OFF_DIAG:   rdMux = diag_q & `FFD_DIAG_MASK;
      `FFD_OFF_STATUS: rdMux = 32'(status_q);
      `FFD_OFF_MASK:   rdMux = mask_q;
      `FFD_OFF_CTRL:   rdMux = ctrl_q;
      `FFD_OFF_OC_A:   rdMux = {16'h0, peakA};
      `FFD_OFF_OC_B:   rdMux = {16'h0, peakB};
      `FFD_OFF_OC_C:   rdMux = {16'h0, peakC};
      `FFD_OFF_FAULTS: rdMux = {25'h0, evt};
      `FFD_OFF_SMERR:  rdMux = {15'h0, cmdFail_q, smErr_q};
      `FFD_OFF_OCLIM:  rdMux = ocLim_q;
      `FFD_OFF_OCWARN: rdMux = ocWarnCyc_q;
      `FFD_OFF_PTLIM:  rdMux = ptLim_q;
      default:         hit   = 1'b0;
    endcase
  end
  // Handshake: no wait states, ready and error in the first access cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end
  // Read data captured in setup and held until the next read, so
  // it is settled well before the access edge samples it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (rdEn) begin
      prdata <= hit ? rdMux : 32'h0;
    end
  end
endmodule

// *** testbench/ffd_link_master.sv ***
// Fieldbus master stand-in: sync zero pulse each period and
// one receive data pulse a set delay later; an offset beyond
// the period never matches, so that frame's data goes missing
module ffd_link_master (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [15:0] period,
  input  wire logic [15:0] offset,
  output logic             sync0,
  output logic             rxPdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  // Free running frame counter, restarts every period
  always_ff @(posedge core_clk) begin
    if (rst || cnt == period - 16'h0001)
      cnt <= 16'h0000;
    else
      cnt <= cnt + 16'h0001;
    sync0 <= !rst && cnt == 16'h0000;
    rxPdo <= !rst && cnt == offset;
  end
endmodule

// *** testbench/ffd_fault_diag_monitor.sv ***
module ffd_fault_diag_monitor (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire ffd_pkg::ffd_link_s link,
  input wire logic               eeOutdated,
  input wire logic               powerUp,
  input wire logic               eeUpdateStart,
  input wire logic               irq,
  input wire logic               fault,
  input wire logic               warning
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************
  // Bus handshake
  // ****************
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_answer;
    s_setup |=> s_access;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no ready in access cycle");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  property p_errAck;
    pslverr |-> pready;
  endproperty
  a_errAck: assert property (p_errAck)
    else $error("error without ready");
  // ****************
  // Diagnostics
  // ****************
  property p_smWd;
    link.smWdExpired |-> ##[1:3] fault;
  endproperty
  a_smWd: assert property (p_smWd)
    else $error("data watchdog gave no fault");
  property p_syncWd;
    link.syncWdExpired |-> ##[1:3] fault;
  endproperty
  a_syncWd: assert property (p_syncWd)
    else $error("sync watchdog gave no fault");
  property p_pll;
    link.pllUnlocked |-> ##[1:3] fault;
  endproperty
  a_pll: assert property (p_pll)
    else $error("lock loss gave no fault");
  property p_hwWarn;
    link.hwFail |-> ##[1:3] warning;
  endproperty
  a_hwWarn: assert property (p_hwWarn)
    else $error("controller failure gave no warning");
  property p_eeOld;
    eeOutdated |-> ##[1:3] warning;
  endproperty
  a_eeOld: assert property (p_eeOld)
    else $error("stale image gave no warning");
  property p_eeStart;
    eeUpdateStart |-> $past(powerUp) ##1 !eeUpdateStart;
  endproperty
  a_eeStart: assert property (p_eeStart)
    else $error("update start not tied to power-up");
  // Reset must silence every flag, so no disable here
  property p_rstQuiet;
    disable iff (1'b0) rst |=> !irq && !fault && !warning;
  endproperty
  a_rstQuiet: assert property (p_rstQuiet)
    else $error("flag high after reset");
endmodule
bind ffd_fault_diag ffd_fault_diag_monitor i_mon (
  .core_clk, .rst, .psel, .penable, .pready, .pslverr, .link,
  .eeOutdated, .powerUp, .eeUpdateStart, .irq, .fault, .warning
);

// *** testbench/testbench.sv ***
`include "ffd_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, trackErr, exp;
  logic        pready, pslverr, eeOutdated, cmdOk, s0, pdo;
  logic        eeUpdateStart, irq, fault, warning;
  logic [15:0] cmdErrCode, per, off, va, vb;
  logic [4:0]  pul;
  logic [3:0]  linkErr;
  logic [44:0] notes[$];
  int          num_errors, checks, starts;
  int          diagBit[4] = '{8, 2, 1, 0};
  logic [15:0] badOff[2] = '{16'h0005, 16'hffff};
  ffd_pkg::ffd_link_s  link;
  ffd_pkg::ffd_phase_s phase;
  assign link = {linkErr[3:1], pdo, s0, linkErr[0]};
  ffd_fault_diag #(.CW(19)) i_ffd_fault_diag (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link), .phase(phase),
    .trackErr(trackErr), .eeOutdated(eeOutdated),
    .fwDownloadDone(pul[3]), .powerUp(pul[2]), .eeUpdateOk(1'b0),
    .eeUpdateFail(pul[1]), .cmdDone(pul[0]), .cmdOk(cmdOk),
    .cmdErrCode(cmdErrCode), .faultReset(pul[4]),
    .eeUpdateStart(eeUpdateStart), .irq(irq), .fault(fault),
    .warning(warning)
  );
  ffd_link_master i_ffd_link_master (
    .core_clk(core_clk), .rst(rst), .period(per), .offset(off),
    .sync0(s0), .rxPdo(pdo)
  );
  // ****************
  // Helpers
  // ****************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic check(string s, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h got %h", s, e, g);
    end
  endtask
  // One transfer; reads leave a note for the watcher below
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic e = 1'b0);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      notes.push_back({e, a, d});
    tick(1);
    penable <= 1'b1;
    // Wait for ready however long; only the hang guard ends this
    do begin
      tick(1);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic pulse(logic [4:0] m);
    pul <= m;
    tick(1);
    pul <= 5'h00;
    tick(2);
  endtask
  task automatic conclude();
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Read results compared against the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check($sformatf("reg %h", notes[0][43:32]), notes[0][31:0],
            prdata);
      check("pslverr", 32'(notes[0][44]), 32'(pslverr));
      void'(notes.pop_front());
    end
    if (eeUpdateStart === 1'b1)
      starts++;
  end
  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    void'($urandom(90130));
    {rst, psel, penable, pwrite, eeOutdated, cmdOk} = 6'h20;
    {paddr, pwdata, trackErr, cmdErrCode} = '0;
    {pul, linkErr, phase} = '0;
    per = 16'd40;
    off = 16'd20;
    tick(20);
    rst <= 1'b0;
    tick(1);
    apb(1'b0, `FFD_OFF_OCLIM, `FFD_OCLIM_RST);
    apb(1'b0, `FFD_OFF_OCWARN, `FFD_OCWARN_RST);
    apb(1'b0, `FFD_OFF_PTLIM, `FFD_PTLIM_RST);
    apb(1'b0, 12'h0fc, 32'h0, 1'b1);
    apb(1'b1, `FFD_OFF_DIAG, 32'hffffffff);
    tick(200);
    apb(1'b0, `FFD_OFF_DIAG, 32'h0);
    exp = 32'h0;
    for (int i = 0; i < 4; i++) begin
      linkErr[i] <= 1'b1;
      tick(1);
      linkErr[i] <= 1'b0;
      tick(3);
      exp = exp | (32'h1 << diagBit[i]);
      apb(1'b0, `FFD_OFF_DIAG, exp);
      if (i == 0)
        check("fault", 32'h0, 32'(fault));
    end
    check("fault", 32'h1, 32'(fault));
    check("warning", 32'h1, 32'(warning));
    pulse(5'h10);
    apb(1'b0, `FFD_OFF_DIAG, 32'h0);
    foreach (badOff[i]) begin
      off <= badOff[i];
      tick(200);
      apb(1'b0, `FFD_OFF_DIAG, 32'h8);
      off <= 16'd20;
      tick(200);
      pulse(5'h10);
    end
    // Update only counts once a download has completed
    eeOutdated <= 1'b1;
    apb(1'b1, `FFD_OFF_CTRL, 32'h2);
    pulse(5'h04);
    check("eeUpdateStart", 32'h0, starts);
    pulse(5'h08);
    pulse(5'h04);
    check("eeUpdateStart", 32'h1, starts);
    pulse(5'h02);
    apb(1'b0, `FFD_OFF_DIAG, 32'he00);
    eeOutdated <= 1'b0;
    apb(1'b1, `FFD_OFF_CTRL, 32'h0);
    pulse(5'h10);
    apb(1'b1, `FFD_OFF_OCLIM, 32'h100);
    apb(1'b1, `FFD_OFF_OCWARN, 32'h10);
    apb(1'b1, `FFD_OFF_STATUS, 32'hffffffff);
    va = 16'h101 + 16'($urandom_range(0, 16'h0eff));
    vb = 16'h101 + 16'($urandom_range(0, 16'h0eff));
    phase.a <= va;
    tick(5);
    phase.a <= 16'h0;
    tick(3);
    apb(1'b0, `FFD_OFF_OC_A, 32'(va));
    apb(1'b0, `FFD_OFF_STATUS, 32'h4);
    check("fault", 32'h0, 32'(fault));
    phase.b <= vb;
    tick(40);
    phase.b <= 16'h0;
    apb(1'b0, `FFD_OFF_OC_B, 32'(vb));
    apb(1'b0, `FFD_OFF_OC_C, 32'h0);
    apb(1'b0, `FFD_OFF_STATUS, 32'hc);
    check("fault", 32'h1, 32'(fault));
    // Energy drain wait before fault reset, scaled down to cycles
    tick(20);
    pulse(5'h10);
    apb(1'b1, `FFD_OFF_STATUS, 32'hffffffff);
    // Tracking fault unmasked, then masked; warning stays
    apb(1'b1, `FFD_OFF_PTLIM, 32'h100);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `FFD_OFF_CTRL, 32'(m));
      trackErr <= 32'h101 + $urandom_range(0, 255);
      tick(3);
      trackErr <= 32'h0;
      tick(3);
      apb(1'b0, `FFD_OFF_STATUS, m ? 32'h10 : 32'h30);
      if (m == 0)
        apb(1'b1, `FFD_OFF_STATUS, 32'h30);
    end
    apb(1'b1, `FFD_OFF_MASK, 32'h10);
    tick(2);
    check("irq", 32'h1, 32'(irq));
    apb(1'b1, `FFD_OFF_MASK, 32'h0);
    tick(2);
    check("irq", 32'h0, 32'(irq));
    apb(1'b1, `FFD_OFF_MASK, 32'h10);
    apb(1'b1, `FFD_OFF_STATUS, 32'h10);
    tick(2);
    check("irq", 32'h0, 32'(irq));
    cmdErrCode <= 16'($urandom);
    pulse(5'h01);
    apb(1'b0, `FFD_OFF_SMERR, {15'h0, 1'b1, cmdErrCode});
    apb(1'b0, `FFD_OFF_STATUS, 32'h40);
    conclude();
  end
endmodule
